// File: inc/rng_pkg.sv
// Register map, field positions and shared types of the random word generator
package rng_pkg;
    localparam int WORD_W = 16;
    localparam int DIV_W  = 18;
    localparam int LFSR_W = 16;

    // Printed offsets are register indexes; byte address is four times the index
    localparam logic [23:0] IDX_CST   = 24'hFFF280;
    localparam logic [23:0] IDX_WORD  = 24'hFFF282;
    localparam logic [23:0] IDX_DIVH  = 24'hFFF284;
    localparam logic [23:0] IDX_DIVL  = 24'hFFF286;
    localparam logic [23:0] IDX_ISTAT = 24'hFFF288;
    localparam logic [23:0] IDX_WORD_IRQ_MASK_BIT = 24'hFFF28A;

    localparam int CST_EN_BIT    = 0;
    localparam int CST_VALID_BIT = 1;
    localparam int CST_WORD_IRQ_MASK_BIT  = 5;
    localparam int IRQ_WORD_BIT  = 0;
    localparam int IRQ_OVR_BIT   = 1;
    localparam int IRQ_BITS      = 2;
    localparam int DIVH_BITS     = 2;

    localparam logic [DIV_W-1:0]  DIV_RESET  = 18'h083D6;
    localparam logic [LFSR_W-1:0] LFSR_SEED  = 16'h0001;
    localparam logic [LFSR_W-1:0] LFSR_TAPS  = 16'hB400;
    localparam logic [1:0]        RESP_OKAY  = 2'h0;
    localparam logic [1:0]        RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic word_irq_mask_bit;
        logic generator_enable;
    } ctrl_t;

    typedef enum logic [6:0] {
        SEL_NONE  = 7'h01,
        SEL_CST   = 7'h02,
        SEL_WORD  = 7'h04,
        SEL_DIVH  = 7'h08,
        SEL_DIVL  = 7'h10,
        SEL_ISTAT = 7'h20,
        SEL_WORD_IRQ_MASK_BIT = 7'h40
    } reg_sel_t;

    function automatic reg_sel_t decode(input logic [31:0] addr);
        logic [29:0] idx;
        idx = addr[31:2];
        if (idx == {6'h00, IDX_CST}) return SEL_CST;
        if (idx == {6'h00, IDX_WORD}) return SEL_WORD;
        if (idx == {6'h00, IDX_DIVH}) return SEL_DIVH;
        if (idx == {6'h00, IDX_DIVL}) return SEL_DIVL;
        if (idx == {6'h00, IDX_ISTAT}) return SEL_ISTAT;
        if (idx == {6'h00, IDX_WORD_IRQ_MASK_BIT}) return SEL_WORD_IRQ_MASK_BIT;
        return SEL_NONE;
    endfunction : decode

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                            input logic [3:0] strb);
        logic [15:0] res;
        res = old;
        if (strb[0]) res[7:0] = data[7:0];
        if (strb[1]) res[15:8] = data[15:8];
        return res;
    endfunction : merge16
endpackage : rng_pkg

// File: src/true_random_word_generator.sv
// True random word generator with AXI4-Lite register slave
//
// Summary of operation
// - Enable bit clear stops generator and oscillators.
// - Fast oscillator steps an LFSR bitstream.
// - Slow unstable oscillator samples LFSR bitstream.
// - Random bits shift into 16-bit register on strobe.
// - Complete word loads data register, sets valid.
// - Interrupt when valid word and mask bit set.
// - Data read clears word, valid and word interrupt; overrun flag stays.
// - Freeze input suppresses clear-on-read side effects.
// - Low divisor register holds divisor bits 15:0.
// - High divisor register bits 1:0 hold 17:16.
// - Divisor resets to 0x083D6.
// - Reset clears all control/status bits.
// - Valid flag reads one while word unread.
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module true_random_word_generator
    import rng_pkg::*;
#(
    parameter int BITS_PER_WORD = WORD_W
)(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [31:0] awaddr,
    input  wire logic [2:0]  awprot,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [31:0] araddr,
    input  wire logic [2:0]  arprot,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic        fast_osc,
    input  wire logic        slow_osc,
    input  wire logic        freeze,
    output logic             osc_run,
    output logic             random_word_irq
);

    if (BITS_PER_WORD < 1 || BITS_PER_WORD > WORD_W)
    begin : g_bad_width
        $error("BITS_PER_WORD must lie between 1 and 16");
    end

    localparam logic [4:0] LAST_BIT = 5'(BITS_PER_WORD - 1);

    ctrl_t                ctrl_reg;
    logic [DIV_W-1:0]     div_reg;
    logic [DIV_W-1:0]     div_m1;
    logic [DIV_W-1:0]     cnt_reg;
    logic                 strobe_reg;
    logic [LFSR_W-1:0]    lfsr_reg;
    logic                 fast_meta_reg, fast_sync_reg, fast_prev_reg;
    logic                 slow_meta_reg, slow_sync_reg, slow_prev_reg;
    logic                 frz_meta_reg, frz_sync_reg;
    logic                 sampled_reg, rbit_meta_reg, rbit_sync_reg;
    logic [WORD_W-1:0]    shift_reg;
    logic [4:0]           bit_cnt_reg;
    logic [WORD_W-1:0]    word_reg;
    logic                 valid_reg;
    logic [IRQ_BITS-1:0]  istat_reg, word_irq_mask_bit_reg;
    logic                 aw_full_reg, w_full_reg;
    logic [31:0]          aw_addr_reg, w_data_reg;
    logic [3:0]           w_strb_reg;
    logic                 awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
    logic [1:0]           bresp_reg, rresp_reg;
    logic [31:0]          rdata_reg;
    logic                 irq_reg, osc_run_reg;

    logic                 fast_rise, slow_rise, word_done, rd_clear;
    logic                 aw_hs, w_hs, ar_hs, do_write;
    logic [WORD_W-1:0]    new_word;
    reg_sel_t             wsel, rsel;
    logic [15:0]          wmerge_cst, wmerge_divh, wmerge_divl, wmerge_word_irq_mask_bit, wmerge_istat;
    logic [IRQ_BITS-1:0]  istat_set, istat_clr;

    assign awready         = awready_reg;
    assign wready          = wready_reg;
    assign bvalid          = bvalid_reg;
    assign bresp           = bresp_reg;
    assign arready         = arready_reg;
    assign rvalid          = rvalid_reg;
    assign rdata           = rdata_reg;
    assign rresp           = rresp_reg;
    assign random_word_irq = irq_reg;
    assign osc_run         = osc_run_reg;

    // Oscillator pins and freeze are asynchronous to aclk
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            {fast_meta_reg, fast_sync_reg, fast_prev_reg} <= 3'h0;
            {slow_meta_reg, slow_sync_reg, slow_prev_reg} <= 3'h0;
            {frz_meta_reg, frz_sync_reg}                  <= 2'h0;
        end
        else
        begin
            fast_meta_reg <= fast_osc;
            fast_sync_reg <= fast_meta_reg;
            fast_prev_reg <= fast_sync_reg;
            slow_meta_reg <= slow_osc;
            slow_sync_reg <= slow_meta_reg;
            slow_prev_reg <= slow_sync_reg;
            frz_meta_reg  <= freeze;
            frz_sync_reg  <= frz_meta_reg;
        end
    end

    assign fast_rise = fast_sync_reg && !fast_prev_reg;
    assign slow_rise = slow_sync_reg && !slow_prev_reg;

    // Oscillators only run while enabled
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            osc_run_reg <= 1'b0;
        else
            osc_run_reg <= ctrl_reg.generator_enable;
    end

    // Pseudorandom stream, stepped by the fast oscillator
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            lfsr_reg <= LFSR_SEED;
        else if (ctrl_reg.generator_enable && fast_rise)
            lfsr_reg <= {lfsr_reg[LFSR_W-2:0], ^(lfsr_reg & LFSR_TAPS)};
    end

    // Random sampling instant, then resynchronised before use
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sampled_reg   <= 1'b0;
            rbit_meta_reg <= 1'b0;
            rbit_sync_reg <= 1'b0;
        end
        else
        begin
            if (ctrl_reg.generator_enable && slow_rise)
                sampled_reg <= lfsr_reg[LFSR_W-1];
            rbit_meta_reg <= sampled_reg;
            rbit_sync_reg <= rbit_meta_reg;
        end
    end

    // Divisor of zero behaves as one
    assign div_m1 = (div_reg == '0) ? '0 : div_reg - 1'b1;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt_reg    <= DIV_RESET - 1'b1;
            strobe_reg <= 1'b0;
        end
        else if (!ctrl_reg.generator_enable)
        begin
            cnt_reg    <= div_m1;
            strobe_reg <= 1'b0;
        end
        else if (cnt_reg == '0)
        begin
            cnt_reg    <= div_m1;
            strobe_reg <= 1'b1;
        end
        else
        begin
            cnt_reg    <= cnt_reg - 1'b1;
            strobe_reg <= 1'b0;
        end
    end

    assign new_word  = {shift_reg[WORD_W-2:0], rbit_sync_reg};
    assign word_done = strobe_reg && ctrl_reg.generator_enable && bit_cnt_reg == LAST_BIT;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            shift_reg   <= '0;
            bit_cnt_reg <= 5'h00;
        end
        else if (!ctrl_reg.generator_enable)
            bit_cnt_reg <= 5'h00;
        else if (strobe_reg)
        begin
            shift_reg   <= new_word;
            bit_cnt_reg <= word_done ? 5'h00 : bit_cnt_reg + 5'h01;
        end
    end

    // Bus handshakes
    assign aw_hs    = awvalid && awready_reg;
    assign w_hs     = wvalid && wready_reg;
    assign ar_hs    = arvalid && arready_reg;
    assign do_write = aw_full_reg && w_full_reg && !bvalid_reg;
    assign wsel     = decode(aw_addr_reg);
    assign rsel     = decode(araddr);
    assign rd_clear = ar_hs && rsel == SEL_WORD && !frz_sync_reg;

    // New word wins over a clearing read in the same cycle
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            word_reg  <= '0;
            valid_reg <= 1'b0;
        end
        else if (word_done)
        begin
            word_reg  <= new_word;
            valid_reg <= 1'b1;
        end
        else if (rd_clear)
        begin
            word_reg  <= '0;
            valid_reg <= 1'b0;
        end
    end

    assign wmerge_cst   = merge16({10'h000, ctrl_reg.word_irq_mask_bit, 4'h0, ctrl_reg.generator_enable},
                                  w_data_reg, w_strb_reg);
    assign wmerge_divh  = merge16({14'h0000, div_reg[DIV_W-1:WORD_W]}, w_data_reg, w_strb_reg);
    assign wmerge_divl  = merge16(div_reg[WORD_W-1:0], w_data_reg, w_strb_reg);
    assign wmerge_word_irq_mask_bit = merge16({14'h0000, word_irq_mask_bit_reg}, w_data_reg, w_strb_reg);
    assign wmerge_istat = merge16(16'h0000, w_data_reg, w_strb_reg);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_reg  <= '0;
            div_reg   <= DIV_RESET;
            word_irq_mask_bit_reg <= '0;
        end
        else if (do_write)
        begin
            unique case (wsel)
                SEL_CST:
                begin
                    ctrl_reg.generator_enable  <= wmerge_cst[CST_EN_BIT];
                    ctrl_reg.word_irq_mask_bit <= wmerge_cst[CST_WORD_IRQ_MASK_BIT];
                end
                SEL_DIVH:  div_reg[DIV_W-1:WORD_W] <= wmerge_divh[DIVH_BITS-1:0];
                SEL_DIVL:  div_reg[WORD_W-1:0] <= wmerge_divl;
                SEL_WORD_IRQ_MASK_BIT: word_irq_mask_bit_reg <= wmerge_word_irq_mask_bit[IRQ_BITS-1:0];
                SEL_NONE, SEL_WORD, SEL_ISTAT:
                begin
                end
            endcase
        end
    end

    // Sticky events, write one to clear; a new event beats the clear
    always_comb
    begin
        istat_set = '0;
        istat_set[IRQ_WORD_BIT] = word_done;
        istat_set[IRQ_OVR_BIT]  = word_done && valid_reg && !rd_clear;
        istat_clr = (do_write && wsel == SEL_ISTAT) ? wmerge_istat[IRQ_BITS-1:0] : '0;
        if (rd_clear)
            istat_clr[IRQ_WORD_BIT] = 1'b1;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            istat_reg <= '0;
        else
            istat_reg <= (istat_reg & ~istat_clr) | istat_set;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            irq_reg <= 1'b0;
        else
            irq_reg <= (valid_reg && ctrl_reg.word_irq_mask_bit)
                       || |(istat_reg & word_irq_mask_bit_reg);
    end

    // Write channel: address and data taken in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full_reg <= 1'b0;
            w_full_reg  <= 1'b0;
            aw_addr_reg <= '0;
            w_data_reg  <= '0;
            w_strb_reg  <= 4'h0;
            awready_reg <= 1'b0;
            wready_reg  <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= RESP_OKAY;
        end
        else
        begin
            if (aw_hs)
            begin
                aw_full_reg <= 1'b1;
                aw_addr_reg <= awaddr;
            end
            else if (do_write)
                aw_full_reg <= 1'b0;
            if (w_hs)
            begin
                w_full_reg <= 1'b1;
                w_data_reg <= wdata;
                w_strb_reg <= wstrb;
            end
            else if (do_write)
                w_full_reg <= 1'b0;
            awready_reg <= !aw_hs && (do_write || !aw_full_reg);
            wready_reg  <= !w_hs && (do_write || !w_full_reg);
            if (do_write)
            begin
                bvalid_reg <= 1'b1;
                bresp_reg  <= (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            end
            else if (bready)
                bvalid_reg <= 1'b0;
        end
    end

    // Read channel; data read has its clearing effect at acceptance
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= '0;
            rresp_reg   <= RESP_OKAY;
        end
        else
        begin
            arready_reg <= !ar_hs && (!rvalid_reg || rready);
            if (ar_hs)
            begin
                rvalid_reg <= 1'b1;
                rresp_reg  <= (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
                rdata_reg  <= '0;
                unique case (rsel)
                    SEL_CST:
                    begin
                        rdata_reg[CST_EN_BIT]    <= ctrl_reg.generator_enable;
                        rdata_reg[CST_VALID_BIT] <= valid_reg;
                        rdata_reg[CST_WORD_IRQ_MASK_BIT]  <= ctrl_reg.word_irq_mask_bit;
                    end
                    SEL_WORD:  rdata_reg[WORD_W-1:0] <= word_reg;
                    SEL_DIVH:  rdata_reg[DIVH_BITS-1:0] <= div_reg[DIV_W-1:WORD_W];
                    SEL_DIVL:  rdata_reg[WORD_W-1:0] <= div_reg[WORD_W-1:0];
                    SEL_ISTAT: rdata_reg[IRQ_BITS-1:0] <= istat_reg;
                    SEL_WORD_IRQ_MASK_BIT: rdata_reg[IRQ_BITS-1:0] <= word_irq_mask_bit_reg;
                    SEL_NONE:
                    begin
                    end
                endcase
            end
            else if (rready)
                rvalid_reg <= 1'b0;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_osc_halt: assert property (!ctrl_reg.generator_enable |=> !osc_run_reg)
        else $error("oscillators run while disabled");
    chk_lfsr_frozen: assert property (!ctrl_reg.generator_enable |=> $stable(lfsr_reg))
        else $error("lfsr moved while disabled");
    chk_lfsr_step: assert property (ctrl_reg.generator_enable && fast_rise |=> lfsr_reg != $past(lfsr_reg))
        else $error("lfsr did not step on fast edge");
    chk_sample_bit: assert property (ctrl_reg.generator_enable && slow_rise
                                     |=> sampled_reg == $past(lfsr_reg[LFSR_W-1]))
        else $error("sample flop missed the stream bit");
    chk_sync_depth: assert property (##2 rbit_sync_reg == $past(sampled_reg, 2))
        else $error("sampled bit not two stages late");
    chk_shift_in: assert property (strobe_reg && ctrl_reg.generator_enable
                                   |=> shift_reg[0] == $past(rbit_sync_reg))
        else $error("strobe did not shift a bit in");
    chk_word_load: assert property (word_done |=> valid_reg && word_reg == $past(new_word))
        else $error("finished word not loaded");
    chk_irq_raise: assert property ($rose(valid_reg) && ctrl_reg.word_irq_mask_bit |=> irq_reg)
        else $error("interrupt missing for valid word");
    chk_read_clear: assert property (rd_clear && !word_done |=> !valid_reg && word_reg == '0)
        else $error("data read did not clear");
    chk_freeze_keep: assert property (ar_hs && rsel == SEL_WORD && frz_sync_reg && !word_done
                                      |=> $stable(word_reg) && $stable(valid_reg))
        else $error("frozen read cleared data");
    chk_div_reload: assert property (strobe_reg |-> cnt_reg == $past(div_m1))
        else $error("divider did not reload");

    cov_word: cover property (word_done);
    cov_clear: cover property (rd_clear ##1 !valid_reg);
    cov_frozen: cover property (ar_hs && rsel == SEL_WORD && frz_sync_reg);
    cov_irq: cover property ($rose(irq_reg));

endmodule : true_random_word_generator

// File: testbench/true_random_word_generator_tb.sv
// Register-level testbench of the random word generator
`timescale 1ns/10ps
module true_random_word_generator_tb;
    import rng_pkg::*;
    logic        aclk;
    logic        aresetn;
    logic [31:0] awaddr;
    logic        awvalid;
    logic        awready;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        bready;
    logic [31:0] araddr;
    logic        arvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
    logic        rready;
    logic        fast_osc;
    logic        slow_osc;
    logic        freeze;
    logic        osc_run;
    logic        random_word_irq;
    logic [2:0]  osc_cnt;
    int          fails;
    int          samples_checked;
    int          cycles;
    logic [31:0] d;
    logic [31:0] w1;
    logic [1:0]  r;

    true_random_word_generator u_dut (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .fast_osc(fast_osc), .slow_osc(slow_osc), .freeze(freeze),
        .osc_run(osc_run), .random_word_irq(random_word_irq)
    );

    initial
    begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    // Oscillator stand-ins, suspended while the block halts them; slow one spans several clocks
    always @(posedge aclk)
    begin
        if (osc_run === 1'b1)
        begin
            fast_osc <= ~fast_osc;
            osc_cnt  <= osc_cnt + 3'h1;
            slow_osc <= osc_cnt[2];
        end
    end

    function automatic logic [31:0] addr_of(input logic [23:0] idx);
        return {6'h00, idx, 2'b00};
    endfunction : addr_of

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : stop_test

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
            fails++;
        end
    endtask : check

    task automatic axi_write(input logic [31:0] a, input logic [15:0] v, output logic [1:0] resp);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done  = 1'b0;
        awaddr  <= a;
        wdata   <= {16'h0000, v};
        wstrb   <= 4'hF;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!(aw_done && w_done))
        begin
            @(posedge aclk);
            if (!aw_done && awready === 1'b1)
            begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready === 1'b1)
            begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
        @(posedge aclk);
    endtask : axi_write

    task automatic axi_read(input logic [31:0] a, output logic [31:0] v, output logic [1:0] resp);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1)
            @(posedge aclk);
        v    = rdata;
        resp = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask : axi_read

    task automatic rd_chk(input logic [23:0] idx, input logic [31:0] exp);
        axi_read(addr_of(idx), d, r);
        check({30'h0, r}, {30'h0, RESP_OKAY});
        check(d, exp);
    endtask : rd_chk

    task automatic wr(input logic [23:0] idx, input logic [15:0] v);
        axi_write(addr_of(idx), v, r);
        check({30'h0, r}, {30'h0, RESP_OKAY});
    endtask : wr

    // Hang guard: whole sequence needs a few hundred cycles
    always @(posedge aclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fails++;
            stop_test();
        end
    end

    initial
    begin
        aresetn = 1'b0;
        awaddr = 32'h0;
        awvalid = 1'b0;
        wdata = 32'h0;
        wstrb = 4'h0;
        wvalid = 1'b0;
        bready = 1'b0;
        araddr = 32'h0;
        arvalid = 1'b0;
        rready = 1'b0;
        fast_osc = 1'b0;
        slow_osc = 1'b0;
        freeze = 1'b0;
        osc_cnt = 3'h0;
        fails = 0;
        samples_checked = 0;
        cycles = 0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        check({31'h0, osc_run}, 32'h0);
        rd_chk(IDX_CST, 32'h0);
        rd_chk(IDX_DIVH, 32'h0);
        rd_chk(IDX_DIVL, 32'h83D6);
        rd_chk(IDX_WORD, 32'h0);
        axi_read(32'h0000_1000, d, r);
        check({30'h0, r}, {30'h0, RESP_SLVERR});
        check(d, 32'h0);
        axi_write(32'h0000_1000, 16'hFFFF, r);
        check({30'h0, r}, {30'h0, RESP_SLVERR});
        wr(IDX_DIVH, 16'hFFFF);
        rd_chk(IDX_DIVH, 32'h3);
        wr(IDX_DIVH, 16'h0000);
        // Divisor scaled far down to keep the run short; real software stays at or under 800 Hz
        wr(IDX_DIVL, 16'h0004);
        rd_chk(IDX_DIVL, 32'h4);
        // Enable with mask; valid is read-only so stays clear
        wr(IDX_CST, 16'hFFFF);
        rd_chk(IDX_CST, 32'h21);
        check({31'h0, osc_run}, 32'h1);
        for (int i = 0; i < 1000 && random_word_irq !== 1'b1; i++)
            @(posedge aclk);
        check({31'h0, random_word_irq}, 32'h1);
        // Stop generation so the word cannot change under the freeze reads
        wr(IDX_CST, 16'h0020);
        rd_chk(IDX_CST, 32'h22);
        check({31'h0, osc_run}, 32'h0);
        freeze <= 1'b1;
        repeat (3) @(posedge aclk);
        axi_read(addr_of(IDX_WORD), w1, r);
        rd_chk(IDX_WORD, w1);
        rd_chk(IDX_CST, 32'h22);
        check({31'h0, random_word_irq}, 32'h1);
        freeze <= 1'b0;
        repeat (3) @(posedge aclk);
        rd_chk(IDX_WORD, w1);
        rd_chk(IDX_WORD, 32'h0);
        rd_chk(IDX_CST, 32'h20);
        check({31'h0, random_word_irq}, 32'h0);
        // Own status/mask pair: raise masked, unmask, clear by write-one
        wr(IDX_ISTAT, 16'h0003);
        wr(IDX_WORD_IRQ_MASK_BIT, 16'h0000);
        wr(IDX_CST, 16'h0001);
        d = 32'h0;
        for (int i = 0; i < 100 && d[CST_VALID_BIT] !== 1'b1; i++)
            axi_read(addr_of(IDX_CST), d, r);
        wr(IDX_CST, 16'h0000);
        rd_chk(IDX_CST, 32'h2);
        check({31'h0, random_word_irq}, 32'h0);
        axi_read(addr_of(IDX_ISTAT), d, r);
        check({31'h0, d[IRQ_WORD_BIT]}, 32'h1);
        wr(IDX_WORD_IRQ_MASK_BIT, 16'h0001);
        check({31'h0, random_word_irq}, 32'h1);
        rd_chk(IDX_WORD_IRQ_MASK_BIT, 32'h1);
        wr(IDX_ISTAT, 16'h0003);
        rd_chk(IDX_ISTAT, 32'h0);
        check({31'h0, random_word_irq}, 32'h0);
        stop_test();
    end
endmodule : true_random_word_generator_tb
